// ==== core/host_port_map.svh ====
// Purpose: constants for the host strobe port and output controls
// Assumes: single 100 MHz clock, synchronous active-low reset
// Notes: included by every core and bench file
//
// Functional notes
// - select low: separate read and write strobes
// - select high: direction select plus data strobe
// - separate mode writes on write rising edge
// - shared mode writes on strobe rise, direction low
// - shared mode drives data when direction high
// - separate mode drives data while read low
// - format pin selects offset binary or two's complement
// - decode two-bit enable into bus three-states
// - tester mode: eight ten-bit groups
// - normal mode: real and imaginary cascade buses
// - host port responds only while chip select low; output controls act regardless
// - everything updates on clock rising edge
// - reset restores defaults and halts processing
`ifndef HOST_PORT_MAP_SVH
`define HOST_PORT_MAP_SVH

`define ADDR_W 7
`define DATA_W 16
`define REG_DEPTH 128
`define REG_RST 16'h0000

`define WORD_W 20
`define WORD_N 4
`define WORD_MSB 19
`define GRP_W 10
`define GRP_N 8

// word slots of the 80-bit output
`define WORD_RE_OUT 0
`define WORD_IM_OUT 1

// enable codes in normal mode
`define OE_BOTH 2'h0
`define OE_RE_ONLY 2'h1
`define OE_IM_ONLY 2'h2
`define OE_NONE 2'h3

`define HIZ_ALL 8'hFF
`define HIZ_TEST_W1 8'hF3
`define HIZ_NORM_UP 4'hF
`define DATA_RST 16'h0000

`endif

// ==== core/host_port_pkg.sv ====
// Purpose: shared types for the host strobe port
// Assumes: host_port_map.svh holds all numbers
// Notes: pins travel as packed structs
`default_nettype none
`include "host_port_map.svh"

package host_port_pkg;

  // raw pins of the processor port, sampled on clk
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] data;
  } host_req_t;

  // four 20-bit words: re out, im out, re in, im in
  typedef logic [`WORD_N-1:0][`WORD_W-1:0] quad_t;

  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_READ = 2'b01,
    ACC_WRITE = 2'b10
  } acc_state_t;

endpackage
`default_nettype wire

// ==== core/reg_store.sv ====
// Purpose: 128 x 16 configuration store with registered read
// Assumes: one write port, one read port, same clock
// Notes: read returns the old word on a same-cycle write
`timescale 1ns/1ps
`default_nettype none
`include "host_port_map.svh"

module reg_store
  import host_port_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [`ADDR_W-1:0] waddr,
  input wire logic [`DATA_W-1:0] wdata,
  input wire logic [`ADDR_W-1:0] raddr,
  output logic [`DATA_W-1:0] rdata
);

  logic [`REG_DEPTH-1:0][`DATA_W-1:0] mem_reg;
  logic [`REG_DEPTH-1:0][`DATA_W-1:0] mem_next;
  logic [`DATA_W-1:0] rdata_reg;
  logic [`DATA_W-1:0] rdata_next;

  // ==========================================
  // storage
  always_comb begin
    mem_next = mem_reg;
    if (we) begin
      mem_next[waddr] = wdata;
    end
    rdata_next = mem_reg[raddr];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_reg <= {`REG_DEPTH{`REG_RST}};
      rdata_reg <= `DATA_RST;
    end else begin
      mem_reg <= mem_next;
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;

endmodule
`default_nettype wire

// ==== core/host_strobe_port_output_ctrl.sv ====
// Purpose: processor strobe port and output bus format/three-state control
// Assumes: all pins synchronous to clk; strobes sampled, edges found in logic
// Notes: read data and bus drive lag the request by one clock
`timescale 1ns/1ps
`default_nettype none
`include "host_port_map.svh"

module host_strobe_port_output_ctrl
  import host_port_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire host_req_t host,
  output logic [`DATA_W-1:0] data_out,
  output logic data_oe_n,
  input wire logic strobe_style_sel,
  input wire logic out_format_sel,
  input wire logic [1:0] out_hiz_ctrl,
  input wire logic tester_hiz_mode,
  input wire quad_t sample_in,
  output quad_t casc_out,
  output logic [`GRP_N-1:0] casc_oe_n
);

  // ==========================================
  // strobe decode
  logic wr_prev_reg;
  logic wr_prev_next;
  logic wr_rise;
  logic write_now;
  logic read_now;

  always_comb begin
    wr_prev_next = host.wr_n;
  end

  assign wr_rise = !wr_prev_reg && host.wr_n;

  always_comb begin
    write_now = 1'b0;
    read_now = 1'b0;
    if (!host.cs_n) begin
      if (!strobe_style_sel) begin
        write_now = wr_rise;
        read_now = !host.rd_n;
      end else begin
        write_now = wr_rise && !host.rd_n;
        read_now = host.rd_n;
      end
    end
  end

  // ==========================================
  // access state
  acc_state_t acc_reg;
  acc_state_t acc_next;

  always_comb begin
    if (read_now) begin
      acc_next = ACC_READ;
    end else if (write_now) begin
      acc_next = ACC_WRITE;
    end else begin
      acc_next = ACC_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_prev_reg <= 1'b1;
      acc_reg <= ACC_IDLE;
    end else begin
      wr_prev_reg <= wr_prev_next;
      acc_reg <= acc_next;
    end
  end

  always_comb begin
    unique case (acc_reg)
      ACC_READ: data_oe_n = 1'b0;
      ACC_IDLE: data_oe_n = 1'b1;
      ACC_WRITE: data_oe_n = 1'b1;
      default: data_oe_n = 1'b1;
    endcase
  end

  // ==========================================
  // configuration store
  reg_store u_store (
    .clk(clk),
    .rst_n(rst_n),
    .we(write_now),
    .waddr(host.addr),
    .wdata(host.data),
    .raddr(host.addr),
    .rdata(data_out)
  );

  // ==========================================
  // output format
  quad_t casc_reg;
  quad_t casc_next;

  genvar w;
  generate
    for (w = 0; w < `WORD_N; w = w + 1) begin : g_fmt
      // offset binary flips the sign bit
      always_comb begin
        casc_next[w] = sample_in[w];
        casc_next[w][`WORD_MSB] = sample_in[w][`WORD_MSB] ^ out_format_sel;
      end
    end
  endgenerate

  // ==========================================
  // three-state decode
  logic [`GRP_N-1:0] oe_reg;
  logic [`GRP_N-1:0] oe_next;

  genvar g;
  generate
    for (g = 0; g < `GRP_N; g = g + 1) begin : g_oe
      localparam logic [1:0] WORD = 2'(g / 2);
      always_comb begin
        if (tester_hiz_mode) begin
          // ten-bit groups, one group pair (one word) enabled
          oe_next[g] = (out_hiz_ctrl != WORD);
        end else if (WORD == 2'(`WORD_RE_OUT)) begin
          oe_next[g] = (out_hiz_ctrl == `OE_IM_ONLY) || (out_hiz_ctrl == `OE_NONE);
        end else if (WORD == 2'(`WORD_IM_OUT)) begin
          oe_next[g] = (out_hiz_ctrl == `OE_RE_ONLY) || (out_hiz_ctrl == `OE_NONE);
        end else begin
          // cascade input words stay inputs in normal use
          oe_next[g] = 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    // outputs halted and floating in reset
    if (!rst_n) begin
      casc_reg <= '0;
      oe_reg <= `HIZ_ALL;
    end else begin
      casc_reg <= casc_next;
      oe_reg <= oe_next;
    end
  end

  assign casc_out = casc_reg;
  assign casc_oe_n = oe_reg;

  // ==========================================
  // checks
  // write-edge checks skip the first cycle after release, whose edge register still holds its default
  a_sep_write_edge: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) && !strobe_style_sel && !host.cs_n && $rose(host.wr_n) |-> write_now)
    else $error("separate-mode write edge missed");

  a_shared_write_dir: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) && strobe_style_sel && !host.cs_n && $rose(host.wr_n)
    |-> write_now == !host.rd_n)
    else $error("shared-mode write direction wrong");

  a_cs_blocks_access: assert property (@(posedge clk) disable iff (!rst_n)
    host.cs_n |=> data_oe_n && $past(!write_now))
    else $error("access taken without chip select");

  a_sep_read_drive: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n && !strobe_style_sel && !host.rd_n && !host.cs_n |=> !data_oe_n)
    else $error("separate-mode read not driven");

  a_shared_read_drive: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n && strobe_style_sel && host.rd_n && !host.cs_n |=> !data_oe_n)
    else $error("shared-mode read not driven");

  a_bus_release: assert property (@(posedge clk) disable iff (!rst_n)
    !read_now |=> data_oe_n)
    else $error("data bus driven with no read");

  a_read_returns_write: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n && write_now ##1 !write_now ##1 (read_now && host.addr == $past(host.addr, 2) && !write_now)
    |=> data_out == $past(host.data, 3))
    else $error("read-back differs from written word");

  a_format_msb: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n |=> casc_out[`WORD_RE_OUT][`WORD_MSB]
      == ($past(sample_in[`WORD_RE_OUT][`WORD_MSB]) ^ $past(out_format_sel)))
    else $error("output format sign bit wrong");

  a_normal_upper_hiz: assert property (@(posedge clk) disable iff (!rst_n)
    !tester_hiz_mode |=> casc_oe_n[`GRP_N-1:`GRP_N/2] == `HIZ_NORM_UP)
    else $error("cascade input groups driven in normal mode");

  a_normal_decode: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n && !tester_hiz_mode && out_hiz_ctrl == `OE_RE_ONLY |=> casc_oe_n[3:0] == 4'hC)
    else $error("normal enable decode wrong");

  a_tester_groups: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n && tester_hiz_mode && out_hiz_ctrl == 2'h1 |=> casc_oe_n == `HIZ_TEST_W1)
    else $error("tester group decode wrong");

  a_reset_release: assert property (@(posedge clk) disable iff (!rst_n)
    $past(!rst_n) |-> data_oe_n && casc_oe_n == `HIZ_ALL && data_out == `DATA_RST)
    else $error("outputs not at defaults after reset");

  c_sep_write: cover property (@(posedge clk) disable iff (!rst_n)
    !strobe_style_sel && write_now);
  c_shared_write: cover property (@(posedge clk) disable iff (!rst_n)
    strobe_style_sel && write_now);
  c_shared_read: cover property (@(posedge clk) disable iff (!rst_n)
    strobe_style_sel && read_now ##1 !data_oe_n);
  c_tester_mode: cover property (@(posedge clk) disable iff (!rst_n)
    tester_hiz_mode && out_hiz_ctrl == 2'h3);

endmodule
`default_nettype wire

// ==== bench/uproc_model.sv ====
// Purpose: processor model driving the host strobe port
// Assumes: requests change just after clk rises
// Notes: idle data lines toggle, never hold a stale value
`timescale 1ns/1ps
`default_nettype none
`include "host_port_map.svh"

module uproc_model
  import host_port_pkg::*;
(
  input wire logic clk,
  input wire logic shared_mode,
  input wire logic [`DATA_W-1:0] data_out,
  input wire logic data_oe_n,
  output host_req_t host
);
  // ====================
  // bus cycles
  initial begin
    host = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: '0, data: '0};
  end

  task automatic idle();
    host.cs_n <= 1'b1;
    host.rd_n <= 1'b1;
    host.wr_n <= 1'b1;
    host.data <= ~host.data;
  endtask

  task automatic write_word(input logic cs_n, input logic dir, input logic [6:0] a, input logic [15:0] d);
    @(posedge clk);
    host <= '{cs_n: cs_n, rd_n: shared_mode ? dir : 1'b1, wr_n: 1'b0, addr: a, data: d};
    @(posedge clk);
    host.wr_n <= 1'b1;
    @(posedge clk);
    idle();
  endtask

  task automatic read_word(input logic [6:0] a, output logic [15:0] d, output logic oe, output logic oe_rel);
    @(posedge clk);
    // separate mode reads with the strobe low, shared mode with direction high
    host <= '{cs_n: 1'b0, rd_n: shared_mode, wr_n: 1'b1, addr: a, data: ~host.data};
    @(posedge clk);
    #1;
    d = data_out;
    oe = data_oe_n;
    @(posedge clk);
    idle();
    @(posedge clk);
    #1;
    oe_rel = data_oe_n;
  endtask
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
// Purpose: self-checking bench for the host strobe port
// Assumes: store clears on reset, outputs lag one clock
// Notes: random values from an lfsr seeded with 57
`timescale 1ns/1ps
`default_nettype none
`include "host_port_map.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module testbench
  import host_port_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, strobe_style_sel = 1'b0, out_format_sel = 1'b0, tester_hiz_mode = 1'b0;
  logic [1:0] out_hiz_ctrl = 2'h0;
  quad_t sample_in = '0, casc_out;
  host_req_t host;
  logic [15:0] data_out, rd;
  logic data_oe_n, oe, oe_rel;
  logic [7:0] casc_oe_n;
  int n_fail = 0, checks_done = 0;
  logic [31:0] seed = 32'h00000039;
  logic [15:0] mem [128];
  logic [6:0] al [12];

  always #5 clk = ~clk;

  host_strobe_port_output_ctrl dut (.clk(clk), .rst_n(rst_n), .host(host), .data_out(data_out),
    .data_oe_n(data_oe_n), .strobe_style_sel(strobe_style_sel), .out_format_sel(out_format_sel),
    .out_hiz_ctrl(out_hiz_ctrl), .tester_hiz_mode(tester_hiz_mode), .sample_in(sample_in),
    .casc_out(casc_out), .casc_oe_n(casc_oe_n));
  uproc_model cpu (.clk(clk), .shared_mode(strobe_style_sel), .data_out(data_out),
    .data_oe_n(data_oe_n), .host(host));

  // ====================
  // expectations
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic quad_t fmt(input quad_t q, input logic ob);
    quad_t r;
    r = q;
    for (int w = 0; w < 4; w++) r[w][19] = q[w][19] ^ ob;
    return r;
  endfunction

  // groups 4-7 idle outside tester mode
  function automatic logic [7:0] exp_oe(input logic t, input logic [1:0] c);
    if (t) return ~(8'h03 << (2 * c));
    return {4'hF, {2{c[0]}}, {2{c[1]}}};
  endfunction

  // ====================
  // tasks
  task automatic finish_test();
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    `CHK(data_oe_n, 1'b1)
    `CHK(casc_oe_n, 8'hFF)
    `CHK(casc_out, quad_t'(0))
    @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 128; i++) mem[i] = 16'h0000;
  endtask

  task automatic rw_test(input logic mode);
    @(posedge clk);
    strobe_style_sel <= mode;
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      al[i] = (i == 0) ? 7'h00 : (i == 1) ? 7'h7F : seed[6:0];
      cpu.write_word(1'b0, 1'b0, al[i], seed[22:7]);
      mem[al[i]] = seed[22:7];
    end
    cpu.write_word(1'b1, 1'b0, al[2], ~mem[al[2]]);
    if (mode) cpu.write_word(1'b0, 1'b1, al[3], ~mem[al[3]]);
    for (int i = 0; i < 12; i++) begin
      cpu.read_word(al[i], rd, oe, oe_rel);
      `CHK(oe, 1'b0)
      `CHK(rd, mem[al[i]])
      `CHK(oe_rel, 1'b1)
    end
    $display("test strobe mode %0d done", mode);
  endtask

  task automatic out_test();
    quad_t q;
    logic [3:0] m;
    for (int i = 0; i < 40; i++) begin
      for (int w = 0; w < 4; w++) begin
        seed = lfsr(seed);
        q[w] = seed[19:0];
      end
      // tester pin low in random traffic
      m = (i < 16) ? i[3:0] : {seed[25], 1'b0, seed[27:26]};
      @(posedge clk);
      sample_in <= q;
      {out_format_sel, tester_hiz_mode, out_hiz_ctrl} <= m;
      @(posedge clk);
      #1;
      `CHK(casc_out, fmt(q, m[3]))
      `CHK(casc_oe_n, exp_oe(m[2], m[1:0]))
    end
    $display("test output control done");
  endtask

  // ====================
  // sequence
  initial begin
    do_reset();
    rw_test(1'b0);
    rw_test(1'b1);
    out_test();
    cpu.write_word(1'b0, 1'b0, 7'h05, 16'hA5A5);
    // read-back two cycles after the write edge
    cpu.read_word(7'h05, rd, oe, oe_rel);
    `CHK(rd, 16'hA5A5)
    do_reset();
    cpu.read_word(7'h05, rd, oe, oe_rel);
    `CHK(rd, 16'h0000)
    $display("test mid-run reset done");
    finish_test();
  end

  // cut a hang short well past the expected run
  initial begin
    #200000;
    n_fail++;
    finish_test();
  end
endmodule
`default_nettype wire
